// [verilog/spg_top.v]
// The AHB-Lite interface to the registers was chosen for this implementation.
`include "spg_map.vh"

module spg_top (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        trig_ch0_narrow,
  input  wire        trig_ch0_wide,
  input  wire        trig_ch1_narrow,
  input  wire        trig_ch1_wide,
  input  wire [7:0]  gpio_dout,
  input  wire [7:0]  gpio_oe,
  input  wire [7:0]  pin_din,
  output reg  [7:0]  pin_dout,
  output reg  [7:0]  pin_oe
);

  // address check shared by the address-phase write and read decodes
  function hit;
    input [31:0] addr;
    input [7:0]  idx;
    begin
      hit = (addr[31:10] == `SPG_ADDR_HI_ZERO) && (addr[9:2] == idx);
    end
  endfunction

  // true when the address hits one of the seven mapped register indices
  function mapped;
    input [31:0] addr;
    begin
      mapped = hit(addr, `SPG_IDX_CH0) ||
               hit(addr, `SPG_IDX_CH1) ||
               hit(addr, `SPG_IDX_CTRL) ||
               hit(addr, `SPG_IDX_PFS) ||
               hit(addr, `SPG_IDX_TRIG) ||
               hit(addr, `SPG_IDX_STAT) ||
               hit(addr, `SPG_IDX_PIN);
    end
  endfunction

  reg  [7:0]  pattern_control_reg;
  reg  [7:0]  port_function_select;
  reg  [1:0]  wide_timer_trigger_ctrl;
  reg  [1:0]  overrun;
  reg  [1:0]  alt_fresh;
  reg  [1:0]  trig_prev;
  reg         dp_write;
  reg  [7:0]  dp_idx;
  reg  [7:0]  pin_s1;
  reg  [7:0]  pin_s2;
  reg  [7:0]  pin_s3;
  reg  [7:0]  pin_state;
  reg  [31:0] read_word;

  wire        addr_take;
  wire        dp_wr_now;
  wire [1:0]  trig_level;
  wire [1:0]  shift_pulse;
  wire [1:0]  chan_wr;
  wire [1:0]  stepper_select;
  wire [1:0]  reverse_dir;
  wire [1:0]  pattern_select;
  wire [3:0]  latch_q [0:1];
  wire [3:0]  alt_q [0:1];
  wire [7:0]  pattern_out;

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = `SPG_HRESP_OKAY;

  assign addr_take = hsel & htrans[`SPG_HTRANS_NSEQ] & hready;
  assign dp_wr_now = dp_write & hready;

  // address phase capture
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dp_write <= 1'b0;
      dp_idx <= `SPG_RST_BYTE;
    end else if (hready) begin
      dp_write <= addr_take & hwrite & mapped(haddr);
      dp_idx <= haddr[9:2];
    end
  end

  // read data registered at the end of the address phase
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= `SPG_RST_WORD;
    end else if (addr_take & ~hwrite) begin
      hrdata <= read_word;
    end
  end

  // latch nibble reads as zero, it is write-only
  always @* begin
    read_word = `SPG_RST_WORD;
    if (hit(haddr, `SPG_IDX_CH0)) begin
      read_word[`SPG_ALT_HI:`SPG_ALT_LO] = alt_q[0];
    end else if (hit(haddr, `SPG_IDX_CH1)) begin
      read_word[`SPG_ALT_HI:`SPG_ALT_LO] = alt_q[1];
    end else if (hit(haddr, `SPG_IDX_CTRL)) begin
      read_word[7:0] = pattern_control_reg;
    end else if (hit(haddr, `SPG_IDX_PFS)) begin
      read_word[7:0] = port_function_select;
    end else if (hit(haddr, `SPG_IDX_TRIG)) begin
      read_word[1:0] = wide_timer_trigger_ctrl;
    end else if (hit(haddr, `SPG_IDX_STAT)) begin
      read_word[`SPG_STAT_OVR_LO+1:`SPG_STAT_OVR_LO] = overrun;
      read_word[`SPG_STAT_IMG_LO+7:`SPG_STAT_IMG_LO] = pattern_out;
    end else if (hit(haddr, `SPG_IDX_PIN)) begin
      read_word[7:0] = pin_state;
    end
  end

  // shared control, function select and trigger source registers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pattern_control_reg <= `SPG_RST_BYTE;
      port_function_select <= `SPG_RST_BYTE;
      wide_timer_trigger_ctrl <= 2'b00;
    end else if (dp_wr_now) begin
      if (dp_idx == `SPG_IDX_CTRL) begin
        pattern_control_reg <= hwdata[7:0] & `SPG_CTRL_MASK;
      end
      if (dp_idx == `SPG_IDX_PFS) begin
        port_function_select <= hwdata[7:0];
      end
      if (dp_idx == `SPG_IDX_TRIG) begin
        wide_timer_trigger_ctrl <= hwdata[1:0];
      end
    end
  end

  // trigger source per channel, rising edge makes the shift pulse
  assign trig_level[0] = wide_timer_trigger_ctrl[0] ? trig_ch0_wide : trig_ch0_narrow;
  assign trig_level[1] = wide_timer_trigger_ctrl[1] ? trig_ch1_wide : trig_ch1_narrow;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev <= 2'b00;
    end else begin
      trig_prev <= trig_level;
    end
  end

  assign shift_pulse = trig_level & ~trig_prev;

  assign chan_wr[0] = dp_wr_now & (dp_idx == `SPG_IDX_CH0);
  assign chan_wr[1] = dp_wr_now & (dp_idx == `SPG_IDX_CH1);

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_chan
      assign stepper_select[c] = pattern_control_reg[c*`SPG_CTRL_STRIDE+`SPG_CTRL_STEP];
      assign reverse_dir[c] = pattern_control_reg[c*`SPG_CTRL_STRIDE+`SPG_CTRL_REV];
      assign pattern_select[c] = pattern_control_reg[c*`SPG_CTRL_STRIDE+`SPG_CTRL_PAT];

      spg_chan u_chan (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .shift_pulse (shift_pulse[c]),
        .reverse_dir (reverse_dir[c]),
        .excite12    (stepper_select[c] | pattern_select[c]),
        .alt_wr      (chan_wr[c]),
        .latch_wr    (chan_wr[c] & ~pattern_select[c]),
        .wdata       (hwdata[7:0]),
        .latch       (latch_q[c]),
        .alt         (alt_q[c])
      );

      // channel c feeds pins 4c+3..4c
      assign pattern_out[c*4+3:c*4] = latch_q[c];

      // overrun: a shift in pattern mode with no fresh alternate data
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          alt_fresh[c] <= 1'b0;
          overrun[c] <= 1'b0;
        end else begin
          if (chan_wr[c]) begin
            alt_fresh[c] <= 1'b1;
          end else if (shift_pulse[c]) begin
            alt_fresh[c] <= 1'b0;
          end
          // set wins over the write-one clear
          if (shift_pulse[c] & pattern_select[c] & ~alt_fresh[c] & ~chan_wr[c]) begin
            overrun[c] <= 1'b1;
          end else if (dp_wr_now & (dp_idx == `SPG_IDX_STAT) & hwdata[`SPG_STAT_OVR_LO+c]) begin
            overrun[c] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // pin readback through three flops, change taken when stages two and three agree
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= `SPG_RST_BYTE;
      pin_s2 <= `SPG_RST_BYTE;
      pin_s3 <= `SPG_RST_BYTE;
      pin_state <= `SPG_RST_BYTE;
    end else begin
      pin_s1 <= pin_din;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_state <= pin_s3;
      end
    end
  end

  // per-pin routing between general port and pattern output
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_dout <= `SPG_RST_BYTE;
      pin_oe <= `SPG_RST_BYTE;
    end else begin
      pin_dout <= (port_function_select & pattern_out) |
                  (~port_function_select & gpio_dout);
      pin_oe <= port_function_select | gpio_oe;
    end
  end

endmodule

// [verilog/spg_map.vh]
// How it works
// - two 4-bit pattern channels advance on timer trigger pulses
// - channels keep separate state, triggers and pins, share one control register
// - each channel picks its 8-bit timer pair or its own 16-bit timer
// - channel zero drives pins 3..0, channel one drives pins 7..4
// - control register picks stepping or pattern generation per channel
// - channel zero register: latch in 7..4 write-only reset 0, alternate in 3..0
// - channel one register has the same layout
// - pattern generation blocks latch writes, only alternate nibble is written
// - pattern generation shifts exactly like one-two excitation
// - port function select routes each pin to port or pattern bit
// - latch (and alternate in one-two) shifts on trigger rising edge, latch drives port
// - direction 0 shifts output 0 toward 3, direction 1 the reverse
// - one or two phase excitation rotates latch alone, alternate ignored
// - one-two excitation ring order b7 b3 b6 b2 b5 b1 b4 b0
`ifndef SPG_MAP_VH
`define SPG_MAP_VH

// register indices, byte address is index times four
`define SPG_IDX_CH0      8'h4c
`define SPG_IDX_CH1      8'h4d
`define SPG_IDX_CTRL     8'h4e
`define SPG_IDX_PFS      8'h4f
`define SPG_IDX_TRIG     8'h50
`define SPG_IDX_STAT     8'h51
`define SPG_IDX_PIN      8'h52
`define SPG_ADDR_HI_ZERO 22'h000000

// channel register fields
`define SPG_LATCH_HI     7
`define SPG_LATCH_LO     4
`define SPG_ALT_HI       3
`define SPG_ALT_LO       0

// control register fields, channel n at bit base 4*n
`define SPG_CTRL_STEP    0
`define SPG_CTRL_REV     1
`define SPG_CTRL_PAT     2
`define SPG_CTRL_STRIDE  4
`define SPG_CTRL_MASK    8'h77

// status register fields
`define SPG_STAT_OVR_LO  0
`define SPG_STAT_IMG_LO  8

// reset values
`define SPG_RST_BYTE     8'h00
`define SPG_RST_NIB      4'h0
`define SPG_RST_WORD     32'h00000000

// ahb constants
`define SPG_HTRANS_NSEQ  1
`define SPG_HRESP_OKAY   1'b0

`endif

// [verilog/spg_chan.v]
`include "spg_map.vh"

module spg_chan (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       shift_pulse,
  input  wire       reverse_dir,
  input  wire       excite12,
  input  wire       alt_wr,
  input  wire       latch_wr,
  input  wire [7:0] wdata,
  output reg  [3:0] latch,
  output reg  [3:0] alt
);

  reg  [7:0] ring;
  reg  [7:0] next_ring;
  reg  [3:0] next_latch;
  reg  [3:0] next_alt;

  // ring positions: latch bits at odd slots, alternate bits at even slots
  always @* begin
    ring = {latch[3], alt[3], latch[2], alt[2],
            latch[1], alt[1], latch[0], alt[0]};
    next_ring = ring;
    next_latch = latch;
    next_alt = alt;
    if (shift_pulse) begin
      if (excite12) begin
        if (reverse_dir) begin
          next_ring = {ring[0], ring[7:1]};
        end else begin
          next_ring = {ring[6:0], ring[7]};
        end
        next_latch = {next_ring[7], next_ring[5], next_ring[3], next_ring[1]};
        next_alt = {next_ring[6], next_ring[4], next_ring[2], next_ring[0]};
      end else begin
        if (reverse_dir) begin
          next_latch = {latch[0], latch[3:1]};
        end else begin
          next_latch = {latch[2:0], latch[3]};
        end
      end
    end
    // cpu write overrides the shift in the same cycle
    if (latch_wr) begin
      next_latch = wdata[`SPG_LATCH_HI:`SPG_LATCH_LO];
    end
    if (alt_wr) begin
      next_alt = wdata[`SPG_ALT_HI:`SPG_ALT_LO];
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= `SPG_RST_NIB;
      alt <= `SPG_RST_NIB;
    end else begin
      latch <= next_latch;
      alt <= next_alt;
    end
  end

endmodule

// [verif/spg_chk.sv]
`include "spg_map.vh"

module spg_chk (
  input logic        mclk,
  input logic        rst_n,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp,
  input logic        trig_ch0_narrow,
  input logic        trig_ch0_wide,
  input logic        trig_ch1_narrow,
  input logic        trig_ch1_wide,
  input logic [7:0]  gpio_dout,
  input logic [7:0]  gpio_oe,
  input logic [7:0]  pin_dout,
  input logic [7:0]  pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        tk;
  logic        rd;
  logic [11:0] ev;
  logic [11:0] ev_q;
  logic [1:0]  qt;
  logic        wp;
  logic [7:0]  pfs_m;
  assign tk = hsel && htrans[1] && hready;
  assign rd = tk && !hwrite;
  assign ev = {trig_ch1_wide, trig_ch1_narrow, trig_ch0_wide, trig_ch0_narrow, gpio_dout};
  // counts cycles with no write, trigger or port data change
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ev_q <= 12'h000;
      qt <= 2'h0;
    end else begin
      ev_q <= ev;
      if ((tk && hwrite) || ev != ev_q)
        qt <= 2'h0;
      else if (qt != 2'h3)
        qt <= qt + 2'h1;
    end
  end
  // shadow of the port function select, written in the data phase
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= 1'b0;
      pfs_m <= 8'h00;
    end else begin
      wp <= tk && hwrite && haddr == {`SPG_ADDR_HI_ZERO, `SPG_IDX_PFS, 2'b00};
      if (wp)
        pfs_m <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_bus_ok; hreadyout && hresp == `SPG_HRESP_OKAY; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready");
  property p_rd_hold; !$past(rd) |-> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmap; rd && (haddr[31:10] != 22'h0 || haddr[9:2] > `SPG_IDX_PIN) |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_chan_rd; rd && haddr[31:3] == {22'h0, 7'h26} |=> hrdata[31:4] == 28'h0; endproperty
  a_chan_rd: assert property (p_chan_rd) else $error("latch readable");
  property p_ctrl_rd; rd && haddr[31:2] == {22'h0, `SPG_IDX_CTRL} |=> hrdata[31:8] == 24'h0; endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control upper bits");
  property p_stat_rd; rd && haddr[31:2] == {22'h0, `SPG_IDX_STAT} |=> hrdata[31:16] == 16'h0; endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status upper bits");
  property p_oe; $past(rst_n) |-> pin_oe == ($past(gpio_oe) | $past(pfs_m)); endproperty
  a_oe: assert property (p_oe) else $error("enable not passed");
  property p_quiet; qt == 2'h3 |-> $stable(pin_dout); endproperty
  a_quiet: assert property (p_quiet) else $error("pins moved idle");
  c_rd: cover property (rd);
  c_wr: cover property (tk && hwrite);
  c_trig: cover property ($rose(trig_ch0_narrow));
endmodule

bind spg_top spg_chk spg_chk_i (.*);

// [verif/spg_load.sv]
module spg_load (
  input  logic [7:0] pin_dout,
  input  logic [7:0] pin_oe,
  output logic [7:0] pin_din
);
  timeunit 1ns;
  timeprecision 1ns;
  // released pins float high through the pull-up
  assign pin_din = (pin_dout & pin_oe) | ~pin_oe;
endmodule

// [verif/spg_top_bench.sv]
`include "spg_map.vh"

module spg_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q;
  logic [3:0]  trg = 4'h0;
  logic [7:0]  gdo = 8'h00;
  logic [7:0]  goe = 8'hff;
  logic [7:0]  pf, cr, s0, s1, pdi;
  wire  [31:0] hrd;
  wire  [7:0]  pdo, poe;
  wire         hro, hrp;
  int          failures = 0;
  int          total_checks = 0;

  always #50 mclk = ~mclk;

  spg_top spg_top_i (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hro), .hrdata(hrd), .hreadyout(hro),
    .hresp(hrp), .trig_ch0_narrow(trg[0]), .trig_ch0_wide(trg[1]), .trig_ch1_narrow(trg[2]),
    .trig_ch1_wide(trg[3]), .gpio_dout(gdo), .gpio_oe(goe), .pin_din(pdi), .pin_dout(pdo), .pin_oe(poe));
  spg_load spg_load_i (.pin_dout(pdo), .pin_oe(poe), .pin_din(pdi));

  // one shift of {latch, alternate} for a control field {pattern, reverse, stepper}
  function logic [7:0] adv(input logic [7:0] la, input logic [2:0] c);
    logic [7:0] r;
    logic [3:0] l;
    r = {la[7], la[3], la[6], la[2], la[5], la[1], la[4], la[0]};
    r = c[1] ? {r[0], r[7:1]} : {r[6:0], r[7]};
    l = c[1] ? {la[4], la[7:5]} : {la[6:4], la[7]};
    adv = (c[0] | c[2]) ? {r[7], r[5], r[3], r[1], r[6], r[4], r[2], r[0]} : {l, la[3:0]};
  endfunction

  function logic [7:0] ex();
    ex = ({s1[7:4], s0[7:4]} & pf) | (gdo & ~pf);
  endfunction

  task chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge mclk);
    while (hro !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hro !== 1'b1) @(posedge mclk);
    q = hrd;
  endtask

  task wr(input logic [7:0] ix, input logic [7:0] d);
    bus(1'b1, {`SPG_ADDR_HI_ZERO, ix, 2'b00}, {24'h0, d});
  endtask

  task rd(input logic [7:0] ix);
    bus(1'b0, {`SPG_ADDR_HI_ZERO, ix, 2'b00}, 32'h0);
  endtask

  task pulse(input logic [3:0] t, input int hold);
    trg <= t;
    repeat (hold) @(posedge mclk);
    trg <= 4'h0;
    repeat (3) @(posedge mclk);
  endtask

  // pins, alternate nibble of channel zero and both latches
  task look();
    #1;
    chk({24'h0, pdo}, {24'h0, ex()});
    rd(`SPG_IDX_CH0);
    chk(q, {28'h0, s0[3:0]});
    rd(`SPG_IDX_STAT);
    chk({24'h0, q[15:8]}, {24'h0, s1[7:4], s0[7:4]});
  endtask

  task complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    pf = 8'h00;
    s0 = 8'h00;
    s1 = 8'h00;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(`SPG_IDX_CH1);
    chk(q, 32'h0);
    look();
    $display("test reset done");
    pf = 8'hff;
    wr(`SPG_IDX_PFS, pf);
    for (int m = 0; m < 4; m++) begin
      logic [1:0] b;
      b = m[1:0];
      cr = {2'b00, ~b, 2'b00, b};
      s0 = cr[0] ? 8'hc8 : 8'h35;
      s1 = cr[4] ? 8'h91 : 8'h6c;
      wr(`SPG_IDX_CTRL, cr);
      rd(`SPG_IDX_CTRL);
      chk(q, {24'h0, cr});
      wr(`SPG_IDX_CH0, s0);
      wr(`SPG_IDX_CH1, s1);
      @(posedge mclk);
      look();
      for (int k = 1; k < 4; k++) begin
        pulse(4'b0101, k);
        s0 = adv(s0, cr[2:0]);
        s1 = adv(s1, cr[6:4]);
        look();
      end
    end
    $display("test modes done");
    wr(`SPG_IDX_TRIG, 8'h03);
    pulse(4'b0101, 1);
    look();
    pulse(4'b1010, 1);
    s0 = adv(s0, cr[2:0]);
    s1 = adv(s1, cr[6:4]);
    look();
    $display("test source done");
    cr = 8'h05;
    wr(`SPG_IDX_CTRL, cr);
    wr(`SPG_IDX_CH0, 8'hf6);
    s0 = {s0[7:4], 4'h6};
    @(posedge mclk);
    look();
    pulse(4'b1010, 1);
    s0 = adv(s0, cr[2:0]);
    s1 = adv(s1, cr[6:4]);
    look();
    rd(`SPG_IDX_STAT);
    chk({30'h0, q[1:0]}, 32'h0);
    pulse(4'b1010, 1);
    s0 = adv(s0, cr[2:0]);
    s1 = adv(s1, cr[6:4]);
    look();
    rd(`SPG_IDX_STAT);
    chk({30'h0, q[1:0]}, 32'h1);
    wr(`SPG_IDX_STAT, 8'h01);
    rd(`SPG_IDX_STAT);
    chk({30'h0, q[1:0]}, 32'h0);
    pf = 8'h0f;
    gdo <= 8'ha5;
    goe <= 8'h3c;
    wr(`SPG_IDX_PFS, pf);
    @(posedge mclk);
    look();
    chk({24'h0, poe}, {24'h0, pf | goe});
    repeat (4) @(posedge mclk);
    rd(`SPG_IDX_PIN);
    chk(q, {24'h0, (ex() & (pf | goe)) | ~(pf | goe)});
    $display("test pattern done");
    wr(8'h53, 8'hff);
    rd(8'h53);
    chk(q, 32'h0);
    bus(1'b0, 32'h400, 32'h0);
    chk(q, 32'h0);
    $display("test map done");
    complete_run();
  end

  initial begin
    #2000000;
    failures++;
    complete_run();
  end
endmodule
